// file: core/ocas_pkg.sv
// Constants, types and shared decode for the one's-complement add and shift unit
package ocas_pkg;
    localparam int WORD_W = 48;           // Accumulator, auxiliary and exchange width
    localparam int COUNT_W = 7;           // Shift count width
    localparam int ADDR_W = 15;           // Operand address width; upper bits must be zero
    localparam int OPC_W = 6;             // Shift opcode width
    localparam int FLAG_W = 4;            // Number of shift-select flags
    localparam int TOP_BIT = WORD_W - 1;  // Sign bit position

    // Shift opcodes
    localparam logic [OPC_W-1:0] OP_SHR_ACC = 6'h01;
    localparam logic [OPC_W-1:0] OP_SHR_AUX = 6'h02;
    localparam logic [OPC_W-1:0] OP_SHR_BOTH = 6'h03;
    localparam logic [OPC_W-1:0] OP_SHL_ACC = 6'h05;
    localparam logic [OPC_W-1:0] OP_SHL_AUX = 6'h06;
    localparam logic [OPC_W-1:0] OP_SHL_BOTH = 6'h07;

    // Shift-select flag positions
    localparam int FLG_ACC_RIGHT = 0;
    localparam int FLG_AUX_RIGHT = 1;
    localparam int FLG_ACC_LEFT = 2;
    localparam int FLG_AUX_LEFT = 3;

    localparam logic [FLAG_W-1:0] FLAGS_NONE = 4'h0;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 7'h00;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 7'h01;
    localparam logic [WORD_W-1:0] WORD_ZERO = 48'h0;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SUB,
        ST_SHIFT
    } ocas_state_t;

    // Opcode to shift-select flags; zero means not a shift opcode
    function automatic logic [FLAG_W-1:0] ocasOpFlags(input logic [OPC_W-1:0] op);
        logic [FLAG_W-1:0] f;
        f = FLAGS_NONE;
        unique case (op)
            OP_SHR_ACC: f[FLG_ACC_RIGHT] = 1'b1;
            OP_SHR_AUX: f[FLG_AUX_RIGHT] = 1'b1;
            OP_SHR_BOTH: begin
                f[FLG_ACC_RIGHT] = 1'b1;
                f[FLG_AUX_RIGHT] = 1'b1;
            end
            OP_SHL_ACC: f[FLG_ACC_LEFT] = 1'b1;
            OP_SHL_AUX: f[FLG_AUX_LEFT] = 1'b1;
            OP_SHL_BOTH: begin
                f[FLG_ACC_LEFT] = 1'b1;
                f[FLG_AUX_LEFT] = 1'b1;
            end
            default: f = FLAGS_NONE;
        endcase
        return f;
    endfunction : ocasOpFlags
endpackage : ocas_pkg

// file: core/ocas_dp_if.sv
// Carrier between the unit's control and its borrow network and shifter
`timescale 1ns/10ps
`default_nettype none
interface ocas_dp_if;
    import ocas_pkg::*;
    logic [WORD_W-1:0] accHi;      // Accumulator upper rank
    logic [WORD_W-1:0] auxHi;      // Auxiliary upper rank
    logic [WORD_W-1:0] exchHi;     // Exchange upper rank
    logic carryless;               // Borrow sensing disabled
    logic [WORD_W-1:0] toggleMask; // Accumulator bits the add toggles
    logic [FLAG_W-1:0] flags;      // Active shift-select flags
    logic [WORD_W-1:0] shiftAcc;   // Accumulator after one step
    logic [WORD_W-1:0] shiftAux;   // Auxiliary after one step

    modport core (output accHi, auxHi, exchHi, carryless, flags,
                  input toggleMask, shiftAcc, shiftAux);
    modport adder (input accHi, exchHi, carryless, output toggleMask);
    modport shifter (input accHi, auxHi, flags, output shiftAcc, shiftAux);
endinterface : ocas_dp_if
`default_nettype wire

// file: core/ocas_borrow_net.sv
// Borrow network: which accumulator bits the add command toggles
`timescale 1ns/10ps
`default_nettype none
module ocas_borrow_net
    import ocas_pkg::*;
(
    ocas_dp_if.adder dp
);
    logic [WORD_W-1:0] logicDiff;  // Bitwise difference of A and X'
    logic [WORD_W-1:0] genBorrow;  // Bit n demands a borrow from n+1
    logic [WORD_W-1:0] borrowIn;   // Borrow demanded from each bit

    assign logicDiff = dp.accHi ^ ~dp.exchHi;
    assign genBorrow = ~dp.accHi & ~dp.exchHi;

    // Ring ripple; two laps settle every chain, including end-around ones
    always_comb begin
        logic b;
        int idx;
        b = 1'b0;
        idx = 0;
        borrowIn = WORD_ZERO;
        for (int i = 0; i < 2 * WORD_W; i++) begin
            idx = i % WORD_W;
            if (i >= WORD_W) begin
                borrowIn[idx] = b;
            end
            b = genBorrow[idx] | (b & ~logicDiff[idx]);
        end
    end

    // Toggle mask from exchange bit and demanded borrow
    always_comb begin
        if (dp.carryless) begin
            dp.toggleMask = dp.exchHi;
        end else begin
            dp.toggleMask = ~dp.exchHi ^ borrowIn;
        end
    end
endmodule : ocas_borrow_net
`default_nettype wire

// file: core/ocas_shifter.sv
// One-position shift network for accumulator, auxiliary or the joined pair
`timescale 1ns/10ps
`default_nettype none
module ocas_shifter
    import ocas_pkg::*;
(
    ocas_dp_if.shifter dp
);
    logic joinRight; // Both registers move right as one
    logic joinLeft;  // Both registers move left as one

    assign joinRight = dp.flags[FLG_ACC_RIGHT] & dp.flags[FLG_AUX_RIGHT];
    assign joinLeft = dp.flags[FLG_ACC_LEFT] & dp.flags[FLG_AUX_LEFT];

    // Accumulator step, upper rank feeding the lower rank one place over
    always_comb begin
        if (dp.flags[FLG_ACC_RIGHT]) begin
            dp.shiftAcc = {dp.accHi[TOP_BIT], dp.accHi[TOP_BIT:1]};
        end else if (joinLeft) begin
            dp.shiftAcc = {dp.accHi[TOP_BIT-1:0], dp.auxHi[TOP_BIT]};
        end else if (dp.flags[FLG_ACC_LEFT]) begin
            dp.shiftAcc = {dp.accHi[TOP_BIT-1:0], dp.accHi[TOP_BIT]};
        end else begin
            dp.shiftAcc = dp.accHi;
        end
    end

    // Auxiliary step
    always_comb begin
        if (joinRight) begin
            // acc bit zero feeds aux top
            dp.shiftAux = {dp.accHi[0], dp.auxHi[TOP_BIT:1]};
        end else if (dp.flags[FLG_AUX_RIGHT]) begin
            dp.shiftAux = {dp.auxHi[TOP_BIT], dp.auxHi[TOP_BIT:1]};
        end else if (joinLeft) begin
            dp.shiftAux = {dp.auxHi[TOP_BIT-1:0], dp.accHi[TOP_BIT]};
        end else if (dp.flags[FLG_AUX_LEFT]) begin
            dp.shiftAux = {dp.auxHi[TOP_BIT-1:0], dp.auxHi[TOP_BIT]};
        end else begin
            dp.shiftAux = dp.auxHi;
        end
    end
endmodule : ocas_shifter
`default_nettype wire

// file: core/ocas_unit.sv
// Top of the one's-complement add and shift unit: ranks, phases and sequencing
`timescale 1ns/10ps
`default_nettype none
module ocas_unit
    import ocas_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic loadAcc,
    input wire logic [WORD_W-1:0] accIn,
    input wire logic loadAux,
    input wire logic [WORD_W-1:0] auxIn,
    input wire logic loadExch,
    input wire logic [WORD_W-1:0] exchIn,
    input wire logic carrylessAddFlag,
    input wire logic addCmd,
    input wire logic subCmd,
    input wire logic shiftCmd,
    input wire logic [OPC_W-1:0] shiftOpcode,
    input wire logic [ADDR_W-1:0] operandAddr,
    input wire logic faultClear,
    output logic evenPhase,
    output logic [WORD_W-1:0] accLo,
    output logic [WORD_W-1:0] auxLo,
    output logic [WORD_W-1:0] exchLo,
    output logic [COUNT_W-1:0] countLo,
    output logic [FLAG_W-1:0] shiftSelectFlags,
    output logic shiftInProgressFlag,
    output logic shiftDone,
    output logic shiftFault,
    output logic busy
);
    ocas_dp_if dp ();            // Datapath carrier
    ocas_state_t state;          // Sequencer state
    logic [WORD_W-1:0] accHi;    // Accumulator upper rank
    logic [WORD_W-1:0] auxHi;    // Auxiliary upper rank
    logic [WORD_W-1:0] exchHi;   // Exchange upper rank
    logic [COUNT_W-1:0] countHi; // Count upper rank
    logic exchPending;           // Exchange lower rank awaits copy upward
    logic oddPhase;              // Commands are taken on odd phases
    logic idle;                  // No sequence running
    logic addNow;                // An add toggles the accumulator this edge
    logic shiftStart;            // Shift instruction accepted
    logic [FLAG_W-1:0] startFlags;
    logic stepping;              // Shift step on this even phase
    logic accSel;                // Accumulator takes part in the shift
    logic auxSel;                // Auxiliary takes part in the shift

    assign oddPhase = ~evenPhase;
    assign idle = (state == ST_IDLE);
    assign startFlags = ocasOpFlags(shiftOpcode);
    assign shiftStart = idle & oddPhase & shiftCmd & (startFlags != FLAGS_NONE);
    assign addNow = oddPhase & ((idle & addCmd) | (state == ST_SUB));
    assign stepping = evenPhase & (shiftSelectFlags != FLAGS_NONE);
    assign accSel = shiftSelectFlags[FLG_ACC_RIGHT] | shiftSelectFlags[FLG_ACC_LEFT];
    assign auxSel = shiftSelectFlags[FLG_AUX_RIGHT] | shiftSelectFlags[FLG_AUX_LEFT];

    // Datapath hookup
    assign dp.accHi = accHi;
    assign dp.auxHi = auxHi;
    assign dp.exchHi = exchHi;
    // Subtraction always needs borrows, whatever the flag says
    assign dp.carryless = carrylessAddFlag & (state != ST_SUB);
    assign dp.flags = shiftSelectFlags;

    ocas_borrow_net uBorrow (
        .dp(dp.adder)
    );

    ocas_shifter uShift (
        .dp(dp.shifter)
    );

    // Phase alternates every clock; first edge after reset is even
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            evenPhase <= 1'b1;
        end else begin
            evenPhase <= ~evenPhase;
        end
    end

    // Sequencer state
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (oddPhase & subCmd & ~addCmd & ~shiftCmd) begin
                        state <= ST_SUB;
                    end else if (shiftStart & (operandAddr[COUNT_W-1:0] != COUNT_ZERO)) begin
                        state <= ST_SHIFT;
                    end
                end
                ST_SUB: begin
                    if (oddPhase) begin
                        state <= ST_IDLE;
                    end
                end
                ST_SHIFT: begin
                    if (oddPhase & (shiftSelectFlags == FLAGS_NONE)) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Shift-select flags: set at start, cleared on the last step
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            shiftSelectFlags <= FLAGS_NONE;
        end else if (shiftStart & (operandAddr[COUNT_W-1:0] != COUNT_ZERO)) begin
            shiftSelectFlags <= startFlags;
        end else if (stepping & (countHi == COUNT_ONE)) begin
            shiftSelectFlags <= FLAGS_NONE;
        end
    end

    // Shift in progress marker and completion pulse
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            shiftInProgressFlag <= 1'b0;
            shiftDone <= 1'b0;
        end else begin
            shiftDone <= 1'b0;
            if (shiftStart & (operandAddr[COUNT_W-1:0] != COUNT_ZERO)) begin
                shiftInProgressFlag <= 1'b1;
            end else if (shiftStart) begin
                shiftDone <= 1'b1;
            end else if ((state == ST_SHIFT) & oddPhase & (shiftSelectFlags == FLAGS_NONE)
                         & (countLo == COUNT_ZERO)) begin
                shiftInProgressFlag <= 1'b0;
                shiftDone <= 1'b1;
            end
        end
    end

    // Busy mirrors any running sequence, registered for a clean output
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
        end else begin
            busy <= ~((state == ST_IDLE) | ((state == ST_SUB) & oddPhase)
                    | ((state == ST_SHIFT) & oddPhase & (shiftSelectFlags == FLAGS_NONE)))
                    | (oddPhase & idle & subCmd & ~addCmd & ~shiftCmd)
                    | (shiftStart & (operandAddr[COUNT_W-1:0] != COUNT_ZERO));
        end
    end

    // Shift count ranks
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            countLo <= COUNT_ZERO;
            countHi <= COUNT_ZERO;
        end else if (shiftStart) begin
            countLo <= operandAddr[COUNT_W-1:0];
            countHi <= operandAddr[COUNT_W-1:0];
        end else if (stepping) begin
            countLo <= countHi - COUNT_ONE;
        end else if (oddPhase & (state == ST_SHIFT)) begin
            countHi <= countLo;
        end
    end

    // Fault on high address bits; a new fault beats a clear in the same cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            shiftFault <= 1'b0;
        end else if (shiftStart & (operandAddr[ADDR_W-1:COUNT_W] != '0)) begin
            shiftFault <= 1'b1;
        end else if (faultClear) begin
            shiftFault <= 1'b0;
        end
    end

    // Accumulator lower rank: load, add toggle or shift step
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            accLo <= WORD_ZERO;
        end else if (stepping & accSel) begin
            accLo <= dp.shiftAcc;
        end else if (addNow) begin
            accLo <= accLo ^ dp.toggleMask;
        end else if (idle & loadAcc) begin
            accLo <= accIn;
        end
    end

    // Accumulator upper rank follows the lower one
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            accHi <= WORD_ZERO;
        end else if (evenPhase & (shiftSelectFlags == FLAGS_NONE)) begin
            accHi <= accLo;
        end else if (oddPhase & (state == ST_SHIFT)) begin
            // copy shifted word up, the final step's result as well
            accHi <= accLo;
        end
    end

    // Auxiliary ranks are independent; copies happen only for shifts
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            auxLo <= WORD_ZERO;
            auxHi <= WORD_ZERO;
        end else if (stepping & auxSel) begin
            auxLo <= dp.shiftAux;
        end else if (oddPhase & (state == ST_SHIFT)) begin
            // aux copy-back; flags are already clear after the last step
            auxHi <= auxLo;
        end else if (idle & loadAux) begin
            auxLo <= auxIn;
            auxHi <= auxIn;
        end
    end

    // Exchange ranks; the upper rank is what the borrow network reads
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            exchLo <= WORD_ZERO;
            exchHi <= WORD_ZERO;
            exchPending <= 1'b0;
        end else if (oddPhase & idle & subCmd & ~addCmd & ~shiftCmd) begin
            exchHi <= ~exchLo;
            exchPending <= 1'b0;
        end else if (idle & loadExch) begin
            exchLo <= exchIn;
            exchPending <= 1'b1;
        end else if (exchPending) begin
            // One cycle later the new word is visible to the adder
            exchHi <= exchLo;
            exchPending <= 1'b0;
        end
    end
endmodule : ocas_unit
`default_nettype wire

// file: sim/ocas_seq_model.sv
// Sequencer model: issues phase-timed add, subtract and shift requests
`timescale 1ns/10ps
`default_nettype none
module ocas_seq_model
    import ocas_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic evenPhase,
    input wire logic busy,
    output logic addCmd,
    output logic subCmd,
    output logic shiftCmd,
    output logic [OPC_W-1:0] shiftOpcode,
    output logic [ADDR_W-1:0] operandAddr
);
    // Quiet strobes from time zero; nothing is asked before reset ends
    initial begin
        {addCmd, subCmd, shiftCmd} = 3'h0;
        shiftOpcode = 6'h00;
        operandAddr = 15'h0000;
    end

    // One request: kind 0 add, 1 subtract, 2 shift; gap idles first to vary the pace
    task automatic issue(input int kind, input logic [OPC_W-1:0] op,
            input logic [ADDR_W-1:0] addr, input int gap);
        int n;
        n = 0;
        repeat (gap) @(posedge mclk);
        // Launch after an even edge so that the odd edge after it takes the request
        do @(posedge mclk); while (evenPhase !== 1'b1 || busy !== 1'b0 || rstn !== 1'b1);
        addCmd <= (kind == 0);
        subCmd <= (kind == 1);
        shiftCmd <= (kind == 2);
        shiftOpcode <= op;
        operandAddr <= addr;
        @(posedge mclk);
        {addCmd, subCmd, shiftCmd} <= 3'h0;
        // Operand lines mean nothing after the take, so they change value
        shiftOpcode <= ~op;
        operandAddr <= ~addr;
        // Bounded wait for idle; a hang shows up as a wrong result
        do begin
            @(posedge mclk);
            n++;
        end while (busy !== 1'b0 && n < 600);
    endtask : issue
endmodule : ocas_seq_model
`default_nettype wire

// file: sim/ocas_unit_monitor.sv
// Concurrent checks on the add and shift unit's ports
`timescale 1ns/10ps
`default_nettype none
module ocas_unit_monitor
    import ocas_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic addCmd,
    input wire logic subCmd,
    input wire logic shiftCmd,
    input wire logic [OPC_W-1:0] shiftOpcode,
    input wire logic [ADDR_W-1:0] operandAddr,
    input wire logic faultClear,
    input wire logic evenPhase,
    input wire logic [COUNT_W-1:0] countLo,
    input wire logic [FLAG_W-1:0] shiftSelectFlags,
    input wire logic shiftInProgressFlag,
    input wire logic shiftDone,
    input wire logic shiftFault,
    input wire logic busy
);
    logic [FLAG_W-1:0] reqFlags; // Flags the opcode asks for
    logic [COUNT_W-1:0] reqCount; // Count field of the address
    logic shiftTake; // Shift request the unit must accept
    logic subTake; // Subtract request the unit must accept

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // Own opcode decode, kept apart from the design's so a shared slip shows
    always_comb begin
        case (shiftOpcode)
            OP_SHR_ACC: reqFlags = 4'h1;
            OP_SHR_AUX: reqFlags = 4'h2;
            OP_SHR_BOTH: reqFlags = 4'h3;
            OP_SHL_ACC: reqFlags = 4'h4;
            OP_SHL_AUX: reqFlags = 4'h8;
            OP_SHL_BOTH: reqFlags = 4'hc;
            default: reqFlags = FLAGS_NONE; // Not a shift opcode
        endcase
    end
    assign reqCount = operandAddr[COUNT_W-1:0];
    assign shiftTake = shiftCmd && !evenPhase && !busy && !shiftInProgressFlag
        && reqFlags != FLAGS_NONE;
    assign subTake = subCmd && !addCmd && !shiftCmd && !evenPhase && !busy
        && !shiftInProgressFlag;

    a_phase_alternate: assert property (evenPhase |=> !evenPhase ##1 evenPhase)
        else $error("phase did not alternate");
    a_even_decrement: assert property (
        evenPhase && shiftSelectFlags != FLAGS_NONE |=> countLo == $past(countLo) - COUNT_ONE)
        else $error("count not reduced on even step");
    a_odd_hold: assert property (
        !evenPhase && shiftSelectFlags != FLAGS_NONE |=> $stable(countLo))
        else $error("count moved on odd phase");
    a_last_step: assert property (
        evenPhase && shiftSelectFlags != FLAGS_NONE && countLo == COUNT_ONE
        |=> shiftSelectFlags == FLAGS_NONE && countLo == COUNT_ZERO
        ##1 shiftDone && !shiftInProgressFlag && !busy)
        else $error("shift did not end after last step");
    a_flags_inprogress: assert property (
        shiftSelectFlags != FLAGS_NONE |-> shiftInProgressFlag && busy)
        else $error("flags set without shift in progress");
    a_count_load: assert property (shiftTake |=> countLo == $past(reqCount))
        else $error("count not taken from address");
    a_take_flags: assert property (
        shiftTake && reqCount != COUNT_ZERO
        |=> shiftSelectFlags == $past(reqFlags) && shiftInProgressFlag)
        else $error("wrong shift flags for opcode");
    a_zero_count: assert property (
        shiftTake && reqCount == COUNT_ZERO |=> shiftDone && shiftSelectFlags == FLAGS_NONE)
        else $error("zero count shift misbehaved");
    a_fault_raise: assert property (
        shiftTake && operandAddr[ADDR_W-1:COUNT_W] != 8'h00 |=> shiftFault)
        else $error("high address bit raised no fault");
    a_fault_sticky: assert property (shiftFault && !faultClear |=> shiftFault)
        else $error("fault dropped without clear");
    a_done_pulse: assert property (shiftDone |=> !shiftDone)
        else $error("done longer than one cycle");
    a_sub_timing: assert property (subTake |=> busy ##1 busy ##1 !busy)
        else $error("subtract sequence timing wrong");
endmodule : ocas_unit_monitor

bind ocas_unit ocas_unit_monitor u_monitor (
    .mclk(mclk), .rstn(rstn), .addCmd(addCmd), .subCmd(subCmd), .shiftCmd(shiftCmd),
    .shiftOpcode(shiftOpcode), .operandAddr(operandAddr), .faultClear(faultClear),
    .evenPhase(evenPhase), .countLo(countLo), .shiftSelectFlags(shiftSelectFlags),
    .shiftInProgressFlag(shiftInProgressFlag), .shiftDone(shiftDone),
    .shiftFault(shiftFault), .busy(busy)
);
`default_nettype wire

// file: sim/ocas_unit_tb_top.sv
// Self-checking bench for the one's-complement add and shift unit
`timescale 1ns/10ps
`default_nettype none
module ocas_unit_tb_top;
    import ocas_pkg::*;
    logic mclk, rstn, loadAcc, loadAux, loadExch; // Clock, reset, load strobes
    logic carrylessAddFlag, faultClear; // Add mode and fault acknowledge
    logic [WORD_W-1:0] accIn, auxIn, exchIn; // Load data
    logic addCmd, subCmd, shiftCmd; // Requests from the sequencer model
    logic [OPC_W-1:0] shiftOpcode;
    logic [ADDR_W-1:0] operandAddr;
    logic evenPhase, shiftInProgressFlag, shiftDone, shiftFault, busy; // Status
    logic [WORD_W-1:0] accLo, auxLo, exchLo; // Lower ranks
    logic [COUNT_W-1:0] countLo;
    logic [FLAG_W-1:0] shiftSelectFlags;
    int seed = 78; // Fixed seed keeps every run alike
    int fails = 0;
    int totalChecks = 0;
    logic [OPC_W-1:0] ops [6] = '{OP_SHR_ACC, OP_SHR_AUX, OP_SHR_BOTH,
        OP_SHL_ACC, OP_SHL_AUX, OP_SHL_BOTH};
    int cnts [6] = '{0, 1, 96, 127, 2, 48}; // Boundary counts tried first
    logic [WORD_W-1:0] ca [3] = '{48'h0, 48'hffffffffffff, 48'h5}; // Corner addends
    logic [WORD_W-1:0] cx [3] = '{48'hffffffffffff, 48'hffffffffffff, 48'h3};

    ocas_unit u_dut (
        .mclk(mclk), .rstn(rstn), .loadAcc(loadAcc), .accIn(accIn), .loadAux(loadAux),
        .auxIn(auxIn), .loadExch(loadExch), .exchIn(exchIn),
        .carrylessAddFlag(carrylessAddFlag), .addCmd(addCmd), .subCmd(subCmd),
        .shiftCmd(shiftCmd), .shiftOpcode(shiftOpcode), .operandAddr(operandAddr),
        .faultClear(faultClear), .evenPhase(evenPhase), .accLo(accLo), .auxLo(auxLo),
        .exchLo(exchLo), .countLo(countLo), .shiftSelectFlags(shiftSelectFlags),
        .shiftInProgressFlag(shiftInProgressFlag), .shiftDone(shiftDone),
        .shiftFault(shiftFault), .busy(busy)
    );
    ocas_seq_model u_seq (
        .mclk(mclk), .rstn(rstn), .evenPhase(evenPhase), .busy(busy), .addCmd(addCmd),
        .subCmd(subCmd), .shiftCmd(shiftCmd), .shiftOpcode(shiftOpcode),
        .operandAddr(operandAddr)
    );

    // Free-running 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Random 48-bit word from the fixed seed
    function automatic logic [WORD_W-1:0] rnd();
        return WORD_W'({$random(seed), $random(seed)});
    endfunction : rnd

    // Expected sum: A minus complement of X, borrow out of the top taken from bit 0
    function automatic logic [WORD_W-1:0] ocSum(input logic [WORD_W-1:0] a,
            input logic [WORD_W-1:0] x);
        logic [WORD_W:0] d;
        d = {1'b0, a} - {1'b0, ~x};
        return d[WORD_W] ? d[WORD_W-1:0] - 48'h1 : d[WORD_W-1:0];
    endfunction : ocSum

    // Expected {acc, aux} after n one-place steps of an opcode
    function automatic logic [95:0] expShift(input logic [OPC_W-1:0] op,
            input logic [95:0] s, input int n);
        for (int k = 0; k < n; k++) begin
            case (op)
                OP_SHR_ACC: s[95:48] = {s[95], s[95:49]}; // Sign fills, bit 0 lost
                OP_SHR_AUX: s[47:0] = {s[47], s[47:1]};
                OP_SHR_BOTH: s = {s[95], s[95:1]}; // Acc bit 0 enters aux top
                OP_SHL_ACC: s[95:48] = {s[94:48], s[95]}; // Circular
                OP_SHL_AUX: s[47:0] = {s[46:0], s[47]};
                default: s = {s[94:0], s[95]}; // Joined 96-bit rotate
            endcase
        end
        return s;
    endfunction : expShift

    task automatic checkWord(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t word %h expected %h", $time, got, exp);
        end
    endtask : checkWord

    task automatic checkBit(input logic got, input logic exp);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t flag %b expected %b", $time, got, exp);
        end
    endtask : checkBit

    // Load all three registers while idle, then let the copy-up edges pass
    task automatic loadAll(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] q,
            input logic [WORD_W-1:0] x);
        @(posedge mclk);
        accIn <= a;
        auxIn <= q;
        exchIn <= x;
        {loadAcc, loadAux, loadExch} <= 3'h7;
        @(posedge mclk);
        {loadAcc, loadAux, loadExch} <= 3'h0;
        // Stale load data is inverted so a late capture would show
        accIn <= ~a;
        auxIn <= ~q;
        exchIn <= ~x;
        repeat (2) @(posedge mclk);
    endtask : loadAll

    task automatic finalReport();
        if (fails == 0 && totalChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finalReport

    // Watchdog: far beyond the few thousand cycles the tests need
    initial begin
        #200_000;
        fails++;
        finalReport();
    end

    initial begin
        logic [WORD_W-1:0] a, q, x, e;
        logic [95:0] s;
        logic cl;
        int n;
        {loadAcc, loadAux, loadExch, carrylessAddFlag, faultClear} = 5'h00;
        accIn = 48'h0;
        auxIn = 48'h0;
        exchIn = 48'h0;
        rstn = 1'b0;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        // Additions, full and carryless, corners first; odd passes add twice back to back
        for (int i = 0; i < 24; i++) begin
            a = (i < 3) ? ca[i] : rnd();
            x = (i < 3) ? cx[i] : rnd();
            cl = (i > 2) && (i % 3 == 0);
            carrylessAddFlag <= cl;
            e = cl ? (a ^ x) : ocSum(a, x);
            loadAll(a, rnd(), x);
            u_seq.issue(0, OP_SHR_ACC, 15'h0000, i % 4);
            if (i % 2 == 1) begin
                u_seq.issue(0, OP_SHR_ACC, 15'h0000, 0);
                e = cl ? (e ^ x) : ocSum(e, x);
            end
            if (cl) begin
                checkWord(accLo, e);
            end else begin
                checkWord(accLo, e);
            end
        end
        // Subtractions; carryless mode must not leak into them
        for (int i = 0; i < 10; i++) begin
            a = rnd();
            x = (i == 0) ? a : rnd();
            carrylessAddFlag <= 1'(i);
            loadAll(a, rnd(), x);
            u_seq.issue(1, OP_SHR_ACC, 15'h0000, i % 3);
            checkWord(accLo, ocSum(a, ~x));
            checkWord(exchLo, x);
        end
        carrylessAddFlag <= 1'b0;
        // Every shift opcode with boundary then random counts; gap 0 and gap 1 both launch on the same even edge, the call's second
        for (int i = 0; i < 36; i++) begin
            a = rnd();
            q = rnd();
            n = (i < 12) ? cnts[i / 2] : int'(rnd() & 48'h7f);
            loadAll(a, q, rnd());
            u_seq.issue(2, ops[i % 6], ADDR_W'(n), i % 2);
            s = expShift(ops[i % 6], {a, q}, n);
            checkWord(accLo, s[95:48]);
            checkWord(auxLo, s[47:0]);
        end
        // Each high address bit alone raises the fault, which then clears
        for (int i = 0; i < 8; i++) begin
            loadAll(rnd(), rnd(), rnd());
            u_seq.issue(2, OP_SHL_BOTH, {8'h1 << i, 7'h02}, 0);
            checkBit(shiftFault, 1'b1);
            faultClear <= 1'b1;
            @(posedge mclk);
            faultClear <= 1'b0;
            @(posedge mclk);
            checkBit(shiftFault, 1'b0);
        end
        finalReport();
    end
endmodule : ocas_unit_tb_top
`default_nettype wire
